// ---- include/ldc_pkg.sv ----
package ldc_pkg;
    // ------------------------------------------------------------
    // register indexes
    // ------------------------------------------------------------
    localparam logic [7:0] LDC_IDX_ACT = 8'h30;
    localparam logic [7:0] LDC_IDX_B0H = 8'h60;
    localparam logic [7:0] LDC_IDX_B0L = 8'h61;
    localparam logic [7:0] LDC_IDX_B1H = 8'h62;
    localparam logic [7:0] LDC_IDX_B1L = 8'h63;
    localparam logic [7:0] LDC_IDX_IRQ = 8'h70;
    localparam logic [7:0] LDC_IDX_TYP = 8'h71;
    localparam logic [7:0] LDC_IDX_GATE_LO = 8'h60;
    localparam logic [7:0] LDC_IDX_GATE_HI = 8'hFE;
    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    localparam logic [7:0] LDC_ACT_MASK = 8'h01;
    localparam logic [7:0] LDC_IRQ_MASK = 8'h1F;
    localparam logic [7:0] LDC_TYP_MASK = 8'h03;
    localparam int LDC_WAKE_BIT = 4;
    localparam int LDC_POL_BIT = 1;
    localparam int LDC_TRIG_BIT = 0;
    localparam logic [3:0] LDC_IRQ_NONE = 4'h0;
    localparam logic [3:0] LDC_IRQ_BAD = 4'hD;
    localparam logic [7:0] LDC_ZERO = 8'h00;
    // ------------------------------------------------------------
    // per-function image
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] act;
        logic [7:0] b0h;
        logic [7:0] b0l;
        logic [7:0] b1h;
        logic [7:0] b1l;
        logic [7:0] irq;
        logic [7:0] typ;
    } ldc_regs_t;
    localparam ldc_regs_t LDC_RESET = '0;
    // which registers a function implements as writable
    typedef struct packed {
        logic b0h;
        logic b0l;
        logic b1h;
        logic b1l;
        logic irq;
        logic typ;
    } ldc_use_t;
endpackage : ldc_pkg

// ---- core/ldc_func.sv ----
`timescale 1ns/1ps
module ldc_func
    import ldc_pkg::*;
#(
    parameter ldc_use_t USED = '1,
    parameter logic [7:0] B0L_WMASK = 8'hFF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic soft_clear,
    input wire logic wr_en,
    input wire logic [7:0] index,
    input wire logic [7:0] wdata,
    output ldc_regs_t regs
);
    ldc_regs_t next_regs;
    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    always_comb begin
        next_regs = regs;
        if (soft_clear) begin
            next_regs = LDC_RESET;
        end else if (wr_en) begin
            unique case (index)
                LDC_IDX_ACT: next_regs.act = wdata & LDC_ACT_MASK;
                LDC_IDX_B0H: if (USED.b0h) next_regs.b0h = wdata;
                LDC_IDX_B0L: if (USED.b0l) next_regs.b0l = wdata & B0L_WMASK;
                LDC_IDX_B1H: if (USED.b1h) next_regs.b1h = wdata;
                LDC_IDX_B1L: if (USED.b1l) next_regs.b1l = wdata;
                LDC_IDX_IRQ: if (USED.irq) next_regs.irq = wdata & LDC_IRQ_MASK;
                LDC_IDX_TYP: if (USED.typ) next_regs.typ = wdata & LDC_TYP_MASK;
                default: next_regs = regs;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            regs <= LDC_RESET;
        end else begin
            regs <= next_regs;
        end
    end
endmodule : ldc_func

// ---- core/ldc_config_bank.sv ----
`timescale 1ns/1ps
// Overview of operation
// - activation bit resets zero; while zero indexes 60h-FEh are inaccessible.
// - global enable low disables all functions except wake unit and flash interface.
// - registers a function does not use are read-only; writes ignored.
// - base address is high byte 15:8 and low byte 7:0, 60h/61h, 62h/63h.
// - wake enable bit 4 forwards interrupt requests to the wake unit.
// - bits 3:0 pick interrupt line; zero none, 1-12 and 14-15 valid.
// - polarity bit one inverts the request before serialized interrupt output.
// - trigger mode bit is scratch, reads back, no effect on signalling.
module ldc_config_bank
    import ldc_pkg::*;
#(
    parameter int NFUNC = 2,
    parameter logic [NFUNC*8-1:0] FUNC_NUMBER = {8'h05, 8'h04},
    parameter logic [NFUNC-1:0] ALWAYS_ON = 2'b01,
    parameter ldc_use_t [NFUNC-1:0] FUNC_USED = {6'b000011, 6'b110011},
    parameter logic [NFUNC*8-1:0] FUNC_B0L_WMASK = {8'hFF, 8'hE0}
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic soft_reset,
    input wire logic [7:0] function_select,
    input wire logic global_function_enable,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_index,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_hit,
    input wire logic [NFUNC-1:0] func_irq_req,
    output logic [NFUNC-1:0] func_active,
    output logic [NFUNC*16-1:0] io_base_address0,
    output logic [NFUNC*16-1:0] io_base_address1,
    output logic [NFUNC*4-1:0] interrupt_line_number,
    output logic [NFUNC-1:0] serirq_req,
    output logic [NFUNC-1:0] wake_event,
    output logic [NFUNC-1:0] trigger_mode_scratch
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic idx_gated(input logic [7:0] idx);
        idx_gated = (idx >= LDC_IDX_GATE_LO) && (idx <= LDC_IDX_GATE_HI);
    endfunction : idx_gated

    function automatic logic [7:0] pick(input ldc_regs_t r, input logic [7:0] idx);
        unique case (idx)
            LDC_IDX_ACT: pick = r.act;
            LDC_IDX_B0H: pick = r.b0h;
            LDC_IDX_B0L: pick = r.b0l;
            LDC_IDX_B1H: pick = r.b1h;
            LDC_IDX_B1L: pick = r.b1l;
            LDC_IDX_IRQ: pick = r.irq;
            LDC_IDX_TYP: pick = r.typ;
            default: pick = LDC_ZERO;
        endcase
    endfunction : pick

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] rdata;
        logic hit;
        logic [NFUNC-1:0] active;
        logic [NFUNC*16-1:0] base0;
        logic [NFUNC*16-1:0] base1;
        logic [NFUNC*4-1:0] line;
        logic [NFUNC-1:0] req;
        logic [NFUNC-1:0] wake;
        logic [NFUNC-1:0] trig;
    } ldc_state_t;

    ldc_state_t st;
    ldc_state_t next_st;
    ldc_regs_t [NFUNC-1:0] regs;
    logic [NFUNC-1:0] sel;
    logic [NFUNC-1:0] enabled;

    // ------------------------------------------------------------
    // per-function copies
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NFUNC; g++) begin : gen_func
            assign sel[g] = (function_select == FUNC_NUMBER[g*8 +: 8]);
            assign enabled[g] = regs[g].act[0] && (global_function_enable || ALWAYS_ON[g]);
            ldc_func #(
                .USED(FUNC_USED[g]),
                .B0L_WMASK(FUNC_B0L_WMASK[g*8 +: 8])
            ) u_func (
                .clk(clk),
                .resetn(resetn),
                .soft_clear(soft_reset),
                .wr_en(cfg_wr && sel[g] && (!idx_gated(cfg_index) || enabled[g])),
                .index(cfg_index),
                .wdata(cfg_wdata),
                .regs(regs[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // read path and derived outputs
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.hit = 1'b0;
        if (cfg_rd) begin
            next_st.rdata = LDC_ZERO;
        end
        for (int i = 0; i < NFUNC; i++) begin
            if (cfg_rd && sel[i] && (!idx_gated(cfg_index) || enabled[i])) begin
                next_st.rdata = pick(regs[i], cfg_index);
                next_st.hit = 1'b1;
            end
            next_st.active[i] = enabled[i];
            next_st.base0[i*16 +: 16] = {regs[i].b0h, regs[i].b0l};
            next_st.base1[i*16 +: 16] = {regs[i].b1h, regs[i].b1l};
            // a bad line number is routed nowhere rather than to a random line
            if (regs[i].irq[3:0] == LDC_IRQ_BAD) begin
                next_st.line[i*4 +: 4] = LDC_IRQ_NONE;
            end else begin
                next_st.line[i*4 +: 4] = regs[i].irq[3:0];
            end
            next_st.req[i] = enabled[i] && (func_irq_req[i] ^ regs[i].typ[LDC_POL_BIT]);
            next_st.wake[i] = func_irq_req[i] && regs[i].irq[LDC_WAKE_BIT];
            next_st.trig[i] = regs[i].typ[LDC_TRIG_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cfg_rdata = st.rdata;
    assign cfg_hit = st.hit;
    assign func_active = st.active;
    assign io_base_address0 = st.base0;
    assign io_base_address1 = st.base1;
    assign interrupt_line_number = st.line;
    assign serirq_req = st.req;
    assign wake_event = st.wake;
    assign trigger_mode_scratch = st.trig;
endmodule : ldc_config_bank

// ---- dv/ldc_host.sv ----
`timescale 1ns/1ps
module ldc_host (
    input wire logic clk,
    output logic [7:0] function_select = 8'h04,
    output logic global_function_enable = 1'b1,
    output logic cfg_wr = 1'b0,
    output logic cfg_rd = 1'b0,
    output logic [7:0] cfg_index = 8'h00,
    output logic [7:0] cfg_wdata = 8'h00
);
    task automatic acc(input logic [7:0] f, input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        function_select <= f;
        @(posedge clk);
        cfg_wr <= w;
        cfg_rd <= !w;
        cfg_index <= idx;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        cfg_wdata <= ~d;
        // return inside the cycle in which the one-cycle hit pulse stands
        #1;
    endtask : acc
endmodule : ldc_host

// ---- dv/ldc_props.sv ----
`timescale 1ns/1ps
module ldc_props #(parameter int NFUNC = 2) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic soft_reset,
    input wire logic [7:0] function_select,
    input wire logic global_function_enable,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_index,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_hit,
    input wire logic [NFUNC-1:0] func_irq_req,
    input wire logic [NFUNC-1:0] func_active,
    input wire logic [NFUNC*4-1:0] interrupt_line_number,
    input wire logic [NFUNC-1:0] serirq_req,
    input wire logic [NFUNC-1:0] wake_event,
    input wire logic [NFUNC-1:0] trigger_mode_scratch
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_rd(logic [7:0] idx);
        cfg_rd && cfg_index == idx;
    endsequence
    // three idle samples cover the register stage behind the outputs
    sequence s_off;
        !func_active[1] [*3];
    endsequence
    AST_HIT_CAUSE: assert property (cfg_hit |-> $past(cfg_rd))
        else $error("hit without read");
    AST_RSVD: assert property (s_rd(8'h71) |=> cfg_rdata[7:2] == 6'h00)
        else $error("reserved bits set");
    AST_UNMAPPED: assert property (cfg_rd && function_select != 8'h04 && function_select != 8'h05
        |=> !cfg_hit && cfg_rdata == 8'h00) else $error("unselected hit");
    AST_GLOBAL: assert property (!global_function_enable [*2] |-> !func_active[1])
        else $error("active while global off");
    AST_LINE: assert property (interrupt_line_number[3:0] != 4'hD && interrupt_line_number[7:4] != 4'hD)
        else $error("invalid line");
    AST_SERIRQ_OFF: assert property (s_off |-> !serirq_req[1])
        else $error("request while inactive");
    AST_WAKE: assert property (wake_event[1] |-> $past(func_irq_req[1]) || $past(func_irq_req[1], 2))
        else $error("wake without request");
    AST_SOFT: assert property (soft_reset |-> ##2 func_active == '0 && trigger_mode_scratch == '0)
        else $error("soft clear missed");
endmodule : ldc_props

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic soft_reset = 1'b0;
    logic [1:0] func_irq_req = 2'b00;
    logic [7:0] function_select, cfg_index, cfg_wdata, cfg_rdata, interrupt_line_number;
    logic global_function_enable, cfg_wr, cfg_rd, cfg_hit;
    logic [1:0] func_active, serirq_req, wake_event, trigger_mode_scratch;
    logic [31:0] io_base_address0, io_base_address1;
    int mismatches = 0;
    int n_compared = 0;
    ldc_host host_u (
        .clk(clk),
        .function_select(function_select),
        .global_function_enable(global_function_enable),
        .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd),
        .cfg_index(cfg_index),
        .cfg_wdata(cfg_wdata)
    );
    ldc_config_bank dut_u (
        .clk(clk),
        .resetn(resetn),
        .soft_reset(soft_reset),
        .function_select(function_select),
        .global_function_enable(global_function_enable),
        .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd),
        .cfg_index(cfg_index),
        .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata),
        .cfg_hit(cfg_hit),
        .func_irq_req(func_irq_req),
        .func_active(func_active),
        .io_base_address0(io_base_address0),
        .io_base_address1(io_base_address1),
        .interrupt_line_number(interrupt_line_number),
        .serirq_req(serirq_req),
        .wake_event(wake_event),
        .trigger_mode_scratch(trigger_mode_scratch)
    );
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] f, input logic [7:0] idx, input logic [7:0] d);
        host_u.acc(f, 1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [7:0] f, input logic [7:0] idx, input logic [7:0] exp, input logic hit);
        host_u.acc(f, 1'b0, idx, 8'h00);
        check("rdata", cfg_rdata, exp);
        check("hit", cfg_hit, hit);
    endtask : rd
    task automatic req(input logic [1:0] r);
        @(posedge clk);
        func_irq_req <= r;
        repeat (3) @(posedge clk);
        #1;
    endtask : req
    task automatic t_gate;
        rd(8'h04, 8'h30, 8'h00, 1'b1);
        rd(8'h09, 8'h30, 8'h00, 1'b0);
        rd(8'h05, 8'h71, 8'h00, 1'b0);
        wr(8'h05, 8'h70, 8'h1F);
        wr(8'h05, 8'h30, 8'hFF);
        rd(8'h05, 8'h30, 8'h01, 1'b1);
        rd(8'h05, 8'h70, 8'h00, 1'b1);
        wr(8'h05, 8'h60, 8'h55);
        rd(8'h05, 8'h60, 8'h00, 1'b1);
        req(2'b00);
        check("active", func_active, 2'b10);
    endtask : t_gate
    task automatic t_base;
        wr(8'h04, 8'h30, 8'h01);
        wr(8'h04, 8'h60, 8'h12);
        wr(8'h04, 8'h61, 8'hFF);
        wr(8'h04, 8'h62, 8'h77);
        rd(8'h04, 8'h62, 8'h00, 1'b1);
        rd(8'h04, 8'h61, 8'hE0, 1'b1);
        req(2'b00);
        check("base0", io_base_address0[15:0], 16'h12E0);
        check("base1", io_base_address1[15:0], 16'h0000);
    endtask : t_base
    task automatic t_line;
        for (int v = 0; v < 16; v++) begin
            if (v != 13) begin
                wr(8'h05, 8'h70, v[7:0]);
                req(2'b00);
                check("line", interrupt_line_number[7:4], v[3:0]);
            end
        end
        rd(8'h04, 8'h70, 8'h00, 1'b1);
    endtask : t_line
    task automatic t_irq;
        wr(8'h05, 8'h70, 8'h1C);
        wr(8'h05, 8'h71, 8'h02);
        req(2'b10);
        check("wake", wake_event, 2'b10);
        check("serirq", serirq_req, 2'b00);
        req(2'b00);
        check("serirq", serirq_req, 2'b10);
        wr(8'h05, 8'h71, 8'h01);
        req(2'b10);
        check("serirq", serirq_req, 2'b10);
        check("trig", trigger_mode_scratch, 2'b10);
        wr(8'h05, 8'h70, 8'h0C);
        req(2'b10);
        check("wake", wake_event, 2'b00);
        @(posedge clk);
        host_u.global_function_enable <= 1'b0;
        req(2'b00);
        check("active", func_active, 2'b01);
        @(posedge clk);
        host_u.global_function_enable <= 1'b1;
    endtask : t_irq
    task automatic t_soft;
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        req(2'b00);
        check("active", func_active, 2'b00);
        rd(8'h04, 8'h61, 8'h00, 1'b0);
        check("base0", io_base_address0[15:0], 16'h0000);
    endtask : t_soft
    task automatic final_report;
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_gate;
        t_base;
        t_line;
        t_irq;
        t_soft;
        final_report;
    end
    initial begin
        #200000;
        mismatches++;
        final_report;
    end
endmodule : testbench
bind ldc_config_bank ldc_props #(.NFUNC(NFUNC)) props_u (
    .clk(clk),
    .resetn(resetn),
    .soft_reset(soft_reset),
    .function_select(function_select),
    .global_function_enable(global_function_enable),
    .cfg_rd(cfg_rd),
    .cfg_index(cfg_index),
    .cfg_rdata(cfg_rdata),
    .cfg_hit(cfg_hit),
    .func_irq_req(func_irq_req),
    .func_active(func_active),
    .interrupt_line_number(interrupt_line_number),
    .serirq_req(serirq_req),
    .wake_event(wake_event),
    .trigger_mode_scratch(trigger_mode_scratch)
);
